/* File: rti_rc_time_ident.sv */
`timescale 1ns/1ns
`default_nettype none
module rti_rc_time_ident
   import rti_pkg::*;
#(
   parameter int CNT_WIDTH = rti_pkg::CNT_W
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [rti_pkg::AXI_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [rti_pkg::AXI_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic rc_pin_above,
   output logic rc_pin_out,
   output logic rc_pin_oe_n
);
   import rti_pkg::*;

   // write and read channel holding registers
   logic aw_hold_ff;
   logic [AXI_AW-1:0] awaddr_ff;
   logic w_hold_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;

   // measurement state
   rti_state_t state_ff;
   rti_state_t nxt_state;
   rti_ctrl_t ctrl_ff;
   rti_ctrl_t nxt_ctrl;
   rti_stat_t stat_ff;
   rti_stat_t nxt_stat;
   logic [CNT_WIDTH-1:0] cnt_ff;
   logic [CNT_WIDTH-1:0] nxt_cnt;
   logic [CNT_WIDTH-1:0] result_ff;
   logic [CNT_WIDTH-1:0] nxt_result;
   logic pin_oe_n_ff;

   logic aw_fire;
   logic w_fire;
   logic wr_go;
   logic wr_ctrl;
   logic wr_hit;
   logic ar_fire;
   logic rd_hit;
   logic [31:0] rd_mux;
   rti_ctrl_t wr_ctrl_val;
   logic tick;
   logic pin_high;
   logic run;
   logic cnt_top;
   logic start_rise;
   logic disable_wr;

   function automatic logic addr_mapped(input logic [AXI_AW-1:0] a);
      return (a == OFS_CONTROL) || (a == OFS_RESULT);
   endfunction

   // bus slave: address and data taken in either order, answered once both held
   assign awready = !aw_hold_ff && !bvalid_ff;
   assign wready = !w_hold_ff && !bvalid_ff;
   assign aw_fire = awvalid && awready;
   assign w_fire = wvalid && wready;
   assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign wr_hit = addr_mapped(awaddr_ff);
   assign wr_ctrl = wr_go && (awaddr_ff == OFS_CONTROL);
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         awaddr_ff <= '0;
         w_hold_ff <= 1'b0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else begin
         if (aw_fire) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= awaddr;
         end else if (wr_go) begin
            aw_hold_ff <= 1'b0;
         end
         if (w_fire) begin
            w_hold_ff <= 1'b1;
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
         end else if (wr_go) begin
            w_hold_ff <= 1'b0;
         end
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // read side: one read at a time, data registered
   assign arready = !rvalid_ff;
   assign ar_fire = arvalid && arready;
   assign rd_hit = addr_mapped(araddr);
   assign rd_mux = (araddr == OFS_CONTROL) ?
      {22'h0, ctrl_ff.clk_sel, ctrl_ff.enable, ctrl_ff.start, 3'h0, stat_ff.error, stat_ff.tc, stat_ff.done} :
      (araddr == OFS_RESULT) ? 32'(result_ff) : 32'h0;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= RESP_OKAY;
      end else begin
         if (ar_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // byte lanes: lane 0 holds enable and start, lane 1 the clock select
   assign wr_ctrl_val.start = wstrb_ff[0] ? wdata_ff[POS_START] : ctrl_ff.start;
   assign wr_ctrl_val.enable = wstrb_ff[0] ? wdata_ff[POS_ENABLE] : ctrl_ff.enable;
   assign wr_ctrl_val.clk_sel = wstrb_ff[1] ? wdata_ff[POS_CLK_SEL+1:POS_CLK_SEL] : ctrl_ff.clk_sel;
   assign disable_wr = wr_ctrl && !wr_ctrl_val.enable;
   assign start_rise = wr_ctrl && wr_ctrl_val.enable && wr_ctrl_val.start && !ctrl_ff.start;
   assign nxt_ctrl = wr_ctrl ? wr_ctrl_val : ctrl_ff;

   // time base only runs while armed or measuring; idle and done stay quiet
   assign run = (state_ff == RTI_ARMED) || (state_ff == RTI_DISCH) || (state_ff == RTI_CHARGE);

   rti_tick_gen u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(run),
      .sel(ctrl_ff.clk_sel),
      .tick(tick)
   );

   rti_pin_filter u_filt (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_raw(rc_pin_above),
      .pin_clean(pin_high)
   );

   assign cnt_top = (cnt_ff == CNT_WIDTH'(CNT_MAX));

   always_comb begin
      nxt_state = state_ff;
      nxt_stat = stat_ff;
      nxt_cnt = cnt_ff;
      nxt_result = result_ff;
      if (disable_wr) begin
         nxt_state = RTI_IDLE;
         nxt_stat = '0;
         nxt_cnt = '0;
      end else begin
         case (state_ff)
            RTI_IDLE: begin
               if (wr_ctrl && wr_ctrl_val.enable) begin
                  nxt_state = RTI_ARMED;
                  nxt_cnt = '0;
               end
            end
            RTI_ARMED: begin
               if (start_rise) begin
                  nxt_state = RTI_DISCH;
                  nxt_cnt = '0;
               end
            end
            RTI_DISCH: begin
               if (tick) begin
                  if (cnt_top) begin
                     nxt_state = RTI_CHARGE;
                     nxt_stat.tc = 1'b1;
                     nxt_stat.error = pin_high;
                     nxt_cnt = '0;
                  end else begin
                     nxt_cnt = cnt_ff + 1'b1;
                  end
               end
            end
            RTI_CHARGE: begin
               if (tick) begin
                  if (pin_high || cnt_top) begin
                     nxt_state = RTI_DONE;
                     nxt_result = cnt_ff;
                     nxt_stat.done = 1'b1;
                     nxt_stat.error = stat_ff.error || !pin_high;
                  end else begin
                     nxt_cnt = cnt_ff + 1'b1;
                  end
               end
            end
            RTI_DONE: begin
               nxt_state = RTI_DONE;
            end
            default: begin
               nxt_state = RTI_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= RTI_IDLE;
         ctrl_ff <= '{clk_sel: CLK_SEL_RST, enable: 1'b0, start: 1'b0};
         stat_ff <= '0;
         cnt_ff <= '0;
         result_ff <= '0;
         pin_oe_n_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         ctrl_ff <= nxt_ctrl;
         stat_ff <= nxt_stat;
         cnt_ff <= nxt_cnt;
         result_ff <= nxt_result;
         pin_oe_n_ff <= (nxt_state != RTI_DISCH);
      end
   end

   // open-drain pin: only ever pulls low
   assign rc_pin_out = 1'b0;
   assign rc_pin_oe_n = pin_oe_n_ff;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   slow_base_tick_a:
      assert property (tick && ctrl_ff.clk_sel == 2'h3 && $stable(ctrl_ff.clk_sel)
         |=> !tick [*7])
      else $error("eighth-rate base ticked too often");

   disable_idle_a:
      assert property (disable_wr |=> state_ff == RTI_IDLE && stat_ff == '0 && rc_pin_oe_n)
      else $error("disable did not return to idle");

   armed_entry_a:
      assert property (state_ff == RTI_IDLE && wr_ctrl && wr_ctrl_val.enable |=> state_ff == RTI_ARMED && run)
      else $error("enable did not reach the armed state");

   discharge_start_a:
      assert property (state_ff == RTI_ARMED && start_rise |=> state_ff == RTI_DISCH && !rc_pin_oe_n && cnt_ff == '0)
      else $error("start did not begin discharge");

   discharge_end_a:
      assert property (state_ff == RTI_DISCH && tick && cnt_top && !disable_wr
         |=> state_ff == RTI_CHARGE && stat_ff.tc && stat_ff.error == $past(pin_high) && cnt_ff == '0)
      else $error("discharge end handled wrongly");

   charge_timeout_a:
      assert property (state_ff == RTI_CHARGE && tick && cnt_top && !pin_high && !disable_wr
         |=> stat_ff.error && stat_ff.done && result_ff == CNT_WIDTH'(CNT_MAX))
      else $error("charge timeout not flagged");

   charge_capture_a:
      assert property (state_ff == RTI_CHARGE && tick && pin_high && !disable_wr
         |=> state_ff == RTI_DONE && result_ff == $past(cnt_ff) && stat_ff.done)
      else $error("crossing count not stored");

   idle_flags_a:
      assert property (state_ff == RTI_IDLE |-> stat_ff == '0)
      else $error("flag set while idle");

   done_hold_a:
      assert property (state_ff == RTI_DONE && !disable_wr |=> state_ff == RTI_DONE && !run)
      else $error("done state left without disable");

   result_upper_a:
      assert property (ar_fire && araddr == OFS_RESULT |=> rvalid && rdata == 32'($past(result_ff)))
      else $error("result read wrong");

   ctrl_reserved_a:
      assert property (ar_fire && araddr == OFS_CONTROL |=> rdata[31:10] == 22'h0 && rdata[5:3] == 3'h0)
      else $error("reserved control bits not zero");

   unmapped_read_a:
      assert property (ar_fire && !rd_hit |=> rresp == RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");

   unmapped_write_a:
      assert property (wr_go && awaddr_ff != OFS_CONTROL |=> ctrl_ff == $past(ctrl_ff))
      else $error("control changed by a foreign write");

   discharge_count_a:
      assert property (state_ff == RTI_DISCH && tick && !cnt_top && !disable_wr |=> cnt_ff == $past(cnt_ff) + 1'b1)
      else $error("discharge counter did not step");
endmodule
`default_nettype wire

/* File: rti_pkg.sv */
package rti_pkg;
   localparam int AXI_AW = 4;
   localparam logic [AXI_AW-1:0] OFS_CONTROL = 4'h0;
   localparam logic [AXI_AW-1:0] OFS_RESULT = 4'h4;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam int POS_CLK_SEL = 8;
   localparam int POS_ENABLE = 7;
   localparam int POS_START = 6;
   localparam int POS_ERROR = 2;
   localparam int POS_TC = 1;
   localparam int POS_DONE = 0;
   localparam logic [1:0] CLK_SEL_RST = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int DIV_W = 3;
   localparam int FILT_TICKS = 3;
   localparam real SETTLE_WAIT_US = 300.0;
   localparam real CLK_MHZ = 50.0;
   localparam int SETTLE_WAIT_CYC = int'(SETTLE_WAIT_US * CLK_MHZ);

   typedef enum logic [2:0] {
      RTI_IDLE = 3'h0,
      RTI_ARMED = 3'h1,
      RTI_DISCH = 3'h3,
      RTI_CHARGE = 3'h2,
      RTI_DONE = 3'h6
   } rti_state_t;

   typedef struct packed {
      logic [1:0] clk_sel;
      logic enable;
      logic start;
   } rti_ctrl_t;

   typedef struct packed {
      logic error;
      logic tc;
      logic done;
   } rti_stat_t;
endpackage

/* File: rti_tick_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module rti_tick_gen
   import rti_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic [1:0] sel,
   output logic tick
);
   import rti_pkg::*;

   logic [DIV_W-1:0] div_ff;
   logic [DIV_W-1:0] nxt_div;
   logic [DIV_W-1:0] sel_mask;

   function automatic logic [DIV_W-1:0] mask_of(input logic [1:0] s);
      logic [DIV_W-1:0] m;
      m = '0;
      for (int i = 0; i < DIV_W; i++) begin
         if (i < int'(s)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // divide by 1, 2, 4 or 8; stopped counter stands for the gated clock
   assign sel_mask = mask_of(sel);
   assign nxt_div = run ? div_ff + 3'h1 : '0;
   assign tick = run && ((div_ff & sel_mask) == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_ff <= '0;
      end else begin
         div_ff <= nxt_div;
      end
   end
endmodule
`default_nettype wire

/* File: rti_pin_filter.sv */
`timescale 1ns/1ns
`default_nettype none
module rti_pin_filter
   import rti_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin_raw,
   output logic pin_clean
);
   import rti_pkg::*;

   logic [2:0] sync_ff;
   logic [1:0] stable_ff;
   logic clean_ff;
   logic agree;
   logic [1:0] nxt_stable;

   // first stage feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_ff <= 3'h0;
      end else begin
         sync_ff <= {sync_ff[1:0], pin_raw};
      end
   end

   assign agree = (sync_ff[1] == sync_ff[2]);
   assign nxt_stable = !agree || (sync_ff[2] == clean_ff) ? 2'h0 : stable_ff + 2'h1;

   // level must hold three ticks before it is believed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stable_ff <= 2'h0;
         clean_ff <= 1'b0;
      end else begin
         stable_ff <= nxt_stable;
         if (agree && sync_ff[2] != clean_ff && int'(stable_ff) == FILT_TICKS - 1) begin
            clean_ff <= sync_ff[2];
         end
      end
   end

   assign pin_clean = clean_ff;

   glitch_hold_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         $changed(clean_ff) |-> $past(sync_ff[2], 1) == clean_ff && $past(sync_ff[2], 3) == clean_ff)
      else $error("filtered level changed without a stable run");
endmodule
`default_nettype wire

/* File: rti_rc_net.sv */
`timescale 1ns/1ns
`default_nettype none
// behavioural rc network, linear charge and discharge one step per cycle
module rti_rc_net (
   input wire logic aclk,
   input wire logic rc_pin_out,
   input wire logic rc_pin_oe_n,
   input wire logic [1:0] mode,
   input wire logic [15:0] rise_cyc,
   output logic rc_pin_above
);
   int lvl = 0;
   always @(posedge aclk) begin
      if (!rc_pin_oe_n && !rc_pin_out) begin
         if (lvl > 0) lvl <= lvl - 1;
      end else if (lvl < rise_cyc) begin
         lvl <= lvl + 1;
      end
   end
   // mode 1 never crosses, mode 2 shorted high so discharge fails
   assign rc_pin_above = (mode == 2'h2) || (mode == 2'h0 && lvl >= rise_cyc);
endmodule
`default_nettype wire

/* File: rti_rc_time_ident_test.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("Error at %0t ns: got %0h expected %0h", $time, g, e); end end
module rti_rc_time_ident_test;
   import rti_pkg::*;
   // short counter keeps four full measurements within the run budget
   localparam int CW = 8;
   // per row: clock select, pin mode, rise cycles, expected error bit, result window
   typedef struct packed {logic [1:0] sel; logic [1:0] mode; int rise; logic err; int lo; int hi;} rti_row_t;
   rti_row_t rows [4] = '{'{2'h0, 2'h0, 40, 1'b0, 40, 54}, '{2'h1, 2'h2, 0, 1'b1, 0, 8},
      '{2'h2, 2'h1, 0, 1'b1, 255, 255}, '{2'h3, 2'h0, 300, 1'b0, 37, 41}};
   logic aclk = 0;
   logic aresetn = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rd, keep;
   logic [1:0] resp, mode = 2'h0;
   logic [15:0] rise = 16'h0;
   logic awready, wready, bvalid, arready, rvalid, above, pin_out, oe_n;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int failures = 0, n_checks = 0, low_cyc = 0, div, base;

   rti_rc_time_ident #(.CNT_WIDTH(CW)) dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .rc_pin_above(above), .rc_pin_out(pin_out), .rc_pin_oe_n(oe_n));
   rti_rc_net net (.aclk(aclk), .rc_pin_out(pin_out), .rc_pin_oe_n(oe_n), .mode(mode), .rise_cyc(rise),
      .rc_pin_above(above));

   initial begin
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk) if (!oe_n) low_cyc <= low_cyc + 1;

   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw, w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         aw |= awready;
         w |= wready;
         awvalid <= !aw;
         wvalid <= !w;
      end while (!(aw && w));
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdt(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic finish_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         mode <= rows[i].mode;
         rise <= 16'(rows[i].rise);
         div = 1 << rows[i].sel;
         wr(OFS_CONTROL, {22'h0, rows[i].sel, 8'h80}, resp);
         rdt(OFS_CONTROL, rd, resp);
         `CHK(rd, {22'h0, rows[i].sel, 8'h80})
         repeat (SETTLE_WAIT_CYC) @(posedge aclk);
         base = low_cyc;
         wr(OFS_CONTROL, {22'h0, rows[i].sel, 8'hC0}, resp);
         @(posedge aclk);
         `CHK(oe_n, 1'b0)
         `CHK(pin_out, 1'b0)
         rd = 32'h0;
         for (int k = 0; k < 4000 && rd[0] !== 1'b1; k++) rdt(OFS_CONTROL, rd, resp);
         `CHK(rd, {22'h0, rows[i].sel, 8'hC3} | {29'h0, rows[i].err, 2'h0})
         // first tick lands anywhere in the first divided period, so 255 to 256 whole periods
         `CHK(low_cyc - base >= ((1 << CW) - 1) * div + 1 && low_cyc - base <= (1 << CW) * div, 1'b1)
         rdt(OFS_RESULT, rd, resp);
         keep = rd;
         `CHK(rd[31:16] == 16'h0 && rd >= rows[i].lo && rd <= rows[i].hi, 1'b1)
         repeat (50) @(posedge aclk);
         rdt(OFS_CONTROL, rd, resp);
         `CHK(rd[0], 1'b1)
         wr(OFS_CONTROL, 32'h0, resp);
         rdt(OFS_CONTROL, rd, resp);
         `CHK(rd, 32'h0)
         $display("row %0d finished", i);
      end
      // every reserved bit written high, only enable may stick
      wr(OFS_CONTROL, 32'hFFFF_FCBF, resp);
      rdt(OFS_CONTROL, rd, resp);
      `CHK(rd, 32'h0000_0080)
      wr(OFS_RESULT, 32'hFFFF_FFFF, resp);
      rdt(OFS_RESULT, rd, resp);
      `CHK(rd, keep)
      rdt(4'h8, rd, resp);
      `CHK({resp, rd}, {RESP_SLVERR, 32'h0})
      wr(4'hC, 32'hFFFF_FFFF, resp);
      `CHK(resp, RESP_SLVERR)
      $display("register map test finished");
      // abort in mid discharge must release the pin at once
      repeat (SETTLE_WAIT_CYC) @(posedge aclk);
      wr(OFS_CONTROL, 32'h0000_00C0, resp);
      repeat (20) @(posedge aclk);
      wr(OFS_CONTROL, 32'h0, resp);
      @(posedge aclk);
      `CHK(oe_n, 1'b1)
      rdt(OFS_CONTROL, rd, resp);
      `CHK(rd, 32'h0)
      $display("abort test finished");
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rdt(OFS_CONTROL, rd, resp);
      `CHK(rd, 32'h0)
      rdt(OFS_RESULT, rd, resp);
      `CHK(rd, 32'h0)
      $display("reset test finished");
      finish_test;
   end

   // five settle waits and all measurements take about 81000 cycles
   initial begin
      repeat (95000) @(posedge aclk);
      failures++;
      finish_test;
   end
endmodule
`default_nettype wire
